// [inc/seq_pkg.sv]
// Shared constants, register map and carrier types of the multistep speed sequencer.
package seq_pkg;

  localparam int SEG_COUNT = 16;
  localparam int SEG_IDX_W = 4;
  localparam int TIME_W = 16;
  localparam int SP_W = 16;
  localparam int MAG_W = 15;
  localparam int RET_W = 7;

  // Register byte offsets on the Avalon slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_SAVED = 8'h0C;
  localparam logic [1:0] REGION_TIME = 2'h1;
  localparam logic [1:0] REGION_SETPOINT = 2'h2;

  // Field positions.
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_UNIT_BIT = 8;
  localparam int CFG_TARGET_BIT = 12;
  localparam int CFG_RET_LSB = 16;
  localparam int ST_STAGE_LSB = 0;
  localparam int ST_RUNNING_BIT = 4;
  localparam int ST_HOLDING_BIT = 5;
  localparam int ST_POWER_LOST_BIT = 6;
  localparam int ST_SAVED_BIT = 7;
  localparam int ST_ELAPSED_LSB = 16;
  localparam int SEG_RAMP_LSB = 16;

  // Field encodings and reset values.
  localparam logic [1:0] EOC_STOP = 2'h0;
  localparam logic [1:0] EOC_HOLD = 2'h1;
  localparam logic [1:0] EOC_REPEAT = 2'h2;
  localparam logic [RET_W-1:0] RET_DEFAULT = 7'h00;
  localparam logic UNIT_SECONDS = 1'b0;
  localparam logic UNIT_HOURS = 1'b1;
  localparam logic TARGET_FREQ = 1'b0;
  localparam logic TARGET_VOLT = 1'b1;

  // Setpoints are tenths of a percent.
  localparam logic signed [SP_W-1:0] SP_MAX = 16'sh03E8;
  localparam logic signed [SP_W-1:0] SP_MIN = -16'sh03E8;

  // Timing: one running-time count is a tenth of the selected unit.
  localparam int CLK_PERIOD_NS = 10;
  localparam int TENTH_SECOND_NS = 100_000_000;
  localparam int TENTH_CYCLES_DEFAULT = TENTH_SECOND_NS / CLK_PERIOD_NS;
  localparam int TENTHS_PER_HOUR_TENTH = 3600;
  localparam int HOUR_DIV_W = 12;

  typedef struct packed {
    logic [1:0] ramp;
    logic [TIME_W-1:0] run_time;
    logic signed [SP_W-1:0] setpoint;
  } seg_s;

  typedef struct packed {
    logic [MAG_W-1:0] freq;
    logic reverse;
    logic [MAG_W-1:0] volt;
    logic [1:0] ramp;
  } drive_cmd_s;

endpackage

// [verification/drive_model.sv]
// Behavioural drive path: supply monitor and signed speed seen by the motor.
`timescale 1ns/1ps
`default_nettype none
module drive_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cut_power,
  input wire logic [seq_pkg::MAG_W-1:0] freq,
  input wire logic reverse,
  output logic power_fail,
  output logic signed [15:0] speed
);
  import seq_pkg::*;
  // The supply monitor changes only on a clock edge, like a real comparator latch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_fail <= 1'b0;
    end else begin
      power_fail <= cut_power;
    end
  end
  // Direction turns the magnitude into a signed speed for the motor.
  always_comb begin
    speed = reverse ? -$signed({1'b0, freq}) : $signed({1'b0, freq});
  end
endmodule
`default_nettype wire

// [verification/multistep_speed_sequencer_props.sv]
// Port-level checker of the multistep speed sequencer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module seq_props (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic POWER_FAIL,
  input wire logic [seq_pkg::MAG_W-1:0] FREQ_COMMAND,
  input wire logic REVERSE,
  input wire logic [seq_pkg::MAG_W-1:0] VOLTAGE_COMMAND,
  input wire logic [1:0] RAMP_SET,
  input wire logic RUNNING,
  input wire logic [seq_pkg::SEG_IDX_W-1:0] STAGE,
  input wire logic CYCLE_DONE
);
  import seq_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  property p_wait_one;
    $fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_read_answer;
    $rose(AVS_READ) |-> ##[2:4] !AVS_WAITREQUEST;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_rest;
    !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST;
  endproperty
  a_rest: assert property (p_rest) else $error("wait low with no request");
  property p_excl;
    !(FREQ_COMMAND != 15'h0000 && VOLTAGE_COMMAND != 15'h0000);
  endproperty
  a_excl: assert property (p_excl) else $error("both commands driven");
  property p_rev;
    REVERSE |-> FREQ_COMMAND != 15'h0000 && VOLTAGE_COMMAND == 15'h0000;
  endproperty
  a_rev: assert property (p_rev) else $error("reverse without frequency");
  property p_range;
    FREQ_COMMAND <= 15'h03E8 && VOLTAGE_COMMAND <= 15'h03E8;
  endproperty
  a_range: assert property (p_range) else $error("command above full scale");
  property p_idle;
    !RUNNING [*2] |-> FREQ_COMMAND == 15'h0000 && VOLTAGE_COMMAND == 15'h0000 && RAMP_SET == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("output while idle");
  property p_done;
    CYCLE_DONE |=> !CYCLE_DONE;
  endproperty
  a_done: assert property (p_done) else $error("cycle end pulse too long");
  property p_power;
    POWER_FAIL [*6] |-> FREQ_COMMAND == 15'h0000 && VOLTAGE_COMMAND == 15'h0000;
  endproperty
  a_power: assert property (p_power) else $error("output during power loss");

  c_done: cover property (CYCLE_DONE);
  c_rev: cover property ($rose(REVERSE));
  c_volt: cover property (VOLTAGE_COMMAND != 15'h0000);
  c_pf: cover property (POWER_FAIL && RUNNING);
endmodule

bind multistep_speed_sequencer seq_props seq_props_u (.SYS_CLK, .RESET_N, .AVS_ADDRESS,
  .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
  .POWER_FAIL, .FREQ_COMMAND, .REVERSE, .VOLTAGE_COMMAND, .RAMP_SET, .RUNNING, .STAGE,
  .CYCLE_DONE);
`default_nettype wire

// [verification/test_multistep_speed_sequencer.sv]
// Self-checking bench of the multistep speed sequencer over its register bus.
`timescale 1ns/1ps
`default_nettype none
module test_multistep_speed_sequencer;
  import seq_pkg::*;
  logic clk, rst_n, read, write, waitrequest, power_fail, cut_power;
  logic reverse, running, cycle_done;
  logic skip_seen = 1'b0;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  logic [3:0] byteenable, stage;
  logic [MAG_W-1:0] freq, volt;
  logic [1:0] ramp;
  logic signed [15:0] speed;
  int mismatches = 0;
  int num_checks = 0;

  // A short tenth of four cycles keeps every segment within a hundred cycles when timed in seconds.
  multistep_speed_sequencer #(.TENTH_CYCLES(4)) dut_u (.SYS_CLK(clk), .RESET_N(rst_n),
    .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(writedata),
    .AVS_BYTEENABLE(byteenable), .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest),
    .POWER_FAIL(power_fail), .FREQ_COMMAND(freq), .REVERSE(reverse), .VOLTAGE_COMMAND(volt),
    .RAMP_SET(ramp), .RUNNING(running), .STAGE(stage), .CYCLE_DONE(cycle_done));
  drive_model drv_u (.clk(clk), .rst_n(rst_n), .cut_power(cut_power), .freq(freq),
    .reverse(reverse), .power_fail(power_fail), .speed(speed));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Segment 1 has zero time, so its setpoint must never reach the motor.
  always @(negedge clk) begin
    if (freq == 15'h0309) skip_seen <= 1'b1;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic expire();
    mismatches++;
    $display("unexpected at %0t: wait timed out", $time);
    finish_test();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request is held until a rising edge samples waitrequest low; read data are taken there.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) expire();
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask
  function automatic logic cond(input int sel);
    case (sel)
      0: return |freq;
      1: return reverse;
      2: return cycle_done;
      3: return !running;
      default: return volt == 15'h01F4 && freq == 15'h0000;
    endcase
  endfunction
  task automatic wait_for(input int sel);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cond(sel) !== 1'b1 && n < 600);
    if (n >= 600) expire();
  endtask
  task automatic start(input logic [1:0] m, input logic u, input logic t, input logic [6:0] r);
    wr(ADDR_CONFIG, {9'h000, r, 3'h0, t, 3'h0, u, 6'h00, m});
    wr(ADDR_CTRL, 32'h00000001);
  endtask
  task automatic halt();
    wr(ADDR_CTRL, 32'h00000002);
    wait_for(3);
  endtask
  task automatic power_cut();
    @(posedge clk);
    cut_power <= 1'b1;
    repeat (20) @(negedge clk);
  endtask

  initial begin
    rst_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
    cut_power = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_check(ADDR_CONFIG, 32'h00000000);
    for (int i = 0; i < 16; i++) begin
      rd_check(8'h40 + 8'(4 * i), 32'h00000000);
      rd_check(8'h80 + 8'(4 * i), 32'h00000000);
    end
    rd_check(8'hFC, 32'h00000000);
    wr(8'h40, 32'h00010009);
    // Only the low byte lane may change; the ramp field must survive.
    byteenable <= 4'h1;
    wr(8'h40, 32'hFFFFFF05);
    byteenable <= 4'hF;
    rd_check(8'h40, 32'h00010005);
    wr(8'h80, 32'h000001F4);
    wr(8'h84, 32'h00000309);
    wr(8'h48, 32'h00030014);
    wr(8'h88, 32'hFFFFFF06);
    wr(8'h8C, 32'h000007D0);
    rd_check(8'h8C, 32'h000003E8);
    rd_check(8'h48, 32'h00030014);
    // Stop after one cycle.
    start(EOC_STOP, UNIT_SECONDS, TARGET_FREQ, 7'h00);
    wait_for(0);
    check(32'(freq), 32'h000001F4);
    check(32'(ramp), 32'h00000001);
    check(32'(reverse), 32'h00000000);
    wait_for(1);
    check(32'(stage), 32'h00000002);
    check(32'(speed), 32'hFFFFFF06);
    check(32'(ramp), 32'h00000003);
    wait_for(2);
    repeat (20) @(negedge clk);
    check(32'(running), 32'h00000000);
    check(32'(freq), 32'h00000000);
    // Hold the last segment.
    start(EOC_HOLD, UNIT_SECONDS, TARGET_FREQ, 7'h00);
    wait_for(2);
    repeat (20) @(negedge clk);
    check(32'(running), 32'h00000001);
    check(32'(speed), 32'hFFFFFF06);
    halt();
    // Repeat the cycle into the voltage command.
    start(EOC_REPEAT, UNIT_SECONDS, TARGET_VOLT, 7'h00);
    wait_for(2);
    wait_for(4);
    check(32'(stage), 32'h00000000);
    check(32'(running), 32'h00000001);
    halt();
    check(32'(volt), 32'h00000000);
    // Stop retention on, then off.
    start(EOC_STOP, UNIT_SECONDS, TARGET_FREQ, 7'h0A);
    rd_check(ADDR_CONFIG, 32'h000A0000);
    wait_for(1);
    halt();
    wr(ADDR_CTRL, 32'h00000001);
    wait_for(0);
    check(32'(stage), 32'h00000002);
    halt();
    start(EOC_STOP, UNIT_SECONDS, TARGET_FREQ, 7'h00);
    wait_for(0);
    check(32'(stage), 32'h00000000);
    halt();
    // Power-loss retention on, then off.
    start(EOC_STOP, UNIT_SECONDS, TARGET_FREQ, 7'h01);
    wait_for(1);
    power_cut();
    check(32'(freq), 32'h00000000);
    check(32'(running), 32'h00000001);
    cut_power <= 1'b0;
    wait_for(0);
    check(32'(stage), 32'h00000002);
    halt();
    start(EOC_STOP, UNIT_SECONDS, TARGET_FREQ, 7'h00);
    wait_for(1);
    power_cut();
    cut_power <= 1'b0;
    wait_for(0);
    check(32'(stage), 32'h00000000);
    halt();
    // In hours the first segment outlasts the whole run.
    start(EOC_STOP, UNIT_HOURS, TARGET_FREQ, 7'h00);
    repeat (300) @(negedge clk);
    check(32'(stage), 32'h00000000);
    check(32'(freq), 32'h000001F4);
    halt();
    check(32'(skip_seen), 32'h00000000);
    finish_test();
  end
endmodule
`default_nettype wire

// [verilog/multistep_speed_sequencer.sv]
// Sixteen-segment setpoint sequencer with its Avalon-MM register slave.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module multistep_speed_sequencer #(
  parameter int TENTH_CYCLES = seq_pkg::TENTH_CYCLES_DEFAULT
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic POWER_FAIL,
  output logic [seq_pkg::MAG_W-1:0] FREQ_COMMAND,
  output logic REVERSE,
  output logic [seq_pkg::MAG_W-1:0] VOLTAGE_COMMAND,
  output logic [1:0] RAMP_SET,
  output logic RUNNING,
  output logic [seq_pkg::SEG_IDX_W-1:0] STAGE,
  output logic CYCLE_DONE
);
  import seq_pkg::*;

  localparam int DIV_W = $clog2(TENTH_CYCLES + 1);

  typedef enum logic [2:0] {IDLE, SEEK, FETCH, RUN, HOLD} state_e;

  function automatic logic [MAG_W-1:0] magnitude(input logic signed [SP_W-1:0] sp);
    logic signed [SP_W-1:0] pos;
    pos = (sp < 0) ? -sp : sp;
    return pos[MAG_W-1:0];
  endfunction

  function automatic logic signed [SP_W-1:0] clamp(input logic [SP_W-1:0] raw);
    logic signed [SP_W-1:0] v;
    v = signed'(raw);
    if (v > SP_MAX) begin
      return SP_MAX;
    end else if (v < SP_MIN) begin
      return SP_MIN;
    end
    return v;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                         input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Digits other than 0 and 1 behave as 0, so a stray value never retains.
  function automatic logic digit_set(input logic [RET_W-1:0] ret, input logic tens);
    logic [RET_W-1:0] d;
    d = tens ? RET_W'(ret / 7'd10) : RET_W'(ret % 7'd10);
    return d == 7'd1;
  endfunction

  // Bus group.
  logic [1:0] phase, next_phase;
  logic next_wait;
  logic [31:0] bus_word, next_bus_word;
  logic [1:0] eoc_mode, next_eoc_mode;
  logic time_unit, next_time_unit;
  logic target, next_target;
  logic [RET_W-1:0] retention_select, next_retention_select;
  logic run_req, next_run_req, stop_req, next_stop_req;
  logic [31:0] merged;
  logic mem_we, mem_write_time;
  seg_s mem_wdata, mem_q_bus, mem_q_seq;

  // Sequencer group.
  state_e state, next_state;
  logic [SEG_IDX_W-1:0] seg, next_seg;
  logic [TIME_W-1:0] elapsed, next_elapsed;
  seg_s cur, next_cur;
  logic had_active, next_had_active;
  logic power_lost, next_power_lost;
  logic pf_meta, pf_sync;
  logic saved_valid, next_saved_valid;
  logic [SEG_IDX_W-1:0] saved_stage, next_saved_stage;
  logic [TIME_W-1:0] saved_elapsed, next_saved_elapsed;
  logic signed [SP_W-1:0] saved_sp, next_saved_sp;
  drive_cmd_s cmd, next_cmd;
  logic next_running, next_cycle_done, step, drive_on;
  logic tenth_tick, hour_tick, unit_tick, timing;

  seg_mem u_mem (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .we(mem_we),
    .write_time(mem_write_time),
    .waddr(AVS_ADDRESS[5:2]),
    .wdata(mem_wdata),
    .raddr_a(AVS_ADDRESS[5:2]),
    .rdata_a(mem_q_bus),
    .raddr_b(seg),
    .rdata_b(mem_q_seq)
  );

  assign timing = (state == RUN) && !power_lost;

  tick_divider #(.WIDTH(DIV_W)) u_tenth (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .enable(timing),
    .clear(!timing),
    .period(DIV_W'(TENTH_CYCLES)),
    .tick(tenth_tick)
  );

  tick_divider #(.WIDTH(HOUR_DIV_W)) u_hour (
    .clk(SYS_CLK),
    .reset_n(RESET_N),
    .enable(timing && tenth_tick),
    .clear(!timing),
    .period(HOUR_DIV_W'(TENTHS_PER_HOUR_TENTH)),
    .tick(hour_tick)
  );

  assign unit_tick = (time_unit == UNIT_HOURS) ? hour_tick : tenth_tick;

  // Every access answers two cycles after it is raised, so memory reads need no stall path.
  always_comb begin
    next_phase = phase;
    next_wait = AVS_WAITREQUEST;
    next_bus_word = bus_word;
    next_eoc_mode = eoc_mode;
    next_time_unit = time_unit;
    next_target = target;
    next_retention_select = retention_select;
    next_run_req = 1'b0;
    next_stop_req = 1'b0;
    merged = merge(bus_word, AVS_WRITEDATA, AVS_BYTEENABLE);
    mem_we = 1'b0;
    mem_write_time = AVS_ADDRESS[7:6] == REGION_TIME;
    mem_wdata.run_time = merged[TIME_W-1:0];
    mem_wdata.ramp = merged[SEG_RAMP_LSB +: 2];
    mem_wdata.setpoint = clamp(merged[SP_W-1:0]);
    unique case (phase)
      2'h0: begin
        if (AVS_READ || AVS_WRITE) begin
          next_phase = 2'h1;
        end
      end
      2'h1: begin
        next_phase = 2'h2;
        next_wait = 1'b0;
        next_bus_word = '0;
        if (AVS_ADDRESS == ADDR_CONFIG) begin
          next_bus_word[CFG_MODE_LSB +: 2] = eoc_mode;
          next_bus_word[CFG_UNIT_BIT] = time_unit;
          next_bus_word[CFG_TARGET_BIT] = target;
          next_bus_word[CFG_RET_LSB +: RET_W] = retention_select;
        end else if (AVS_ADDRESS == ADDR_STATUS) begin
          next_bus_word[ST_STAGE_LSB +: SEG_IDX_W] = seg;
          next_bus_word[ST_RUNNING_BIT] = RUNNING;
          next_bus_word[ST_HOLDING_BIT] = state == HOLD;
          next_bus_word[ST_POWER_LOST_BIT] = power_lost;
          next_bus_word[ST_SAVED_BIT] = saved_valid;
          next_bus_word[ST_ELAPSED_LSB +: TIME_W] = elapsed;
        end else if (AVS_ADDRESS == ADDR_SAVED) begin
          next_bus_word[SP_W-1:0] = saved_sp;
          next_bus_word[ST_ELAPSED_LSB +: SEG_IDX_W] = saved_stage;
        end else if (AVS_ADDRESS[1:0] == 2'h0 && AVS_ADDRESS[7:6] == REGION_TIME) begin
          next_bus_word[TIME_W-1:0] = mem_q_bus.run_time;
          next_bus_word[SEG_RAMP_LSB +: 2] = mem_q_bus.ramp;
        end else if (AVS_ADDRESS[1:0] == 2'h0 && AVS_ADDRESS[7:6] == REGION_SETPOINT) begin
          next_bus_word = 32'(mem_q_bus.setpoint);
        end
      end
      default: begin
        next_phase = 2'h0;
        next_wait = 1'b1;
        if (AVS_WRITE) begin
          if (AVS_ADDRESS == ADDR_CTRL && AVS_BYTEENABLE[0]) begin
            next_run_req = AVS_WRITEDATA[CTRL_RUN_BIT];
            next_stop_req = AVS_WRITEDATA[CTRL_STOP_BIT];
          end else if (AVS_ADDRESS == ADDR_CONFIG) begin
            next_eoc_mode = merged[CFG_MODE_LSB +: 2];
            next_time_unit = merged[CFG_UNIT_BIT];
            next_target = merged[CFG_TARGET_BIT];
            next_retention_select = merged[CFG_RET_LSB +: RET_W];
          end else if (AVS_ADDRESS[1:0] == 2'h0 &&
                       (AVS_ADDRESS[7:6] == REGION_TIME ||
                        AVS_ADDRESS[7:6] == REGION_SETPOINT)) begin
            mem_we = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase <= 2'h0;
      AVS_WAITREQUEST <= 1'b1;
      bus_word <= 32'h0000_0000;
      eoc_mode <= EOC_STOP;
      time_unit <= UNIT_SECONDS;
      target <= TARGET_FREQ;
      retention_select <= RET_DEFAULT;
      run_req <= 1'b0;
      stop_req <= 1'b0;
    end else begin
      phase <= next_phase;
      AVS_WAITREQUEST <= next_wait;
      bus_word <= next_bus_word;
      eoc_mode <= next_eoc_mode;
      time_unit <= next_time_unit;
      target <= next_target;
      retention_select <= next_retention_select;
      run_req <= next_run_req;
      stop_req <= next_stop_req;
    end
  end

  assign AVS_READDATA = bus_word;

  // Sequencer: a table walk reads one segment per two cycles through the second read port.
  always_comb begin
    next_state = state;
    next_seg = seg;
    next_elapsed = elapsed;
    next_cur = cur;
    next_had_active = had_active;
    next_power_lost = pf_sync;
    next_saved_valid = saved_valid;
    next_saved_stage = saved_stage;
    next_saved_elapsed = saved_elapsed;
    next_saved_sp = saved_sp;
    next_cycle_done = 1'b0;
    step = 1'b0;
    if (stop_req) begin
      if (state != IDLE) begin
        next_state = IDLE;
        if (digit_set(retention_select, 1'b1)) begin
          next_saved_valid = 1'b1;
          next_saved_stage = seg;
          next_saved_elapsed = elapsed;
          next_saved_sp = cur.setpoint;
        end
      end
    end else if (power_lost) begin
      // While power is gone the stage, elapsed time and running value stand frozen.
      if (!pf_sync && state != IDLE && !digit_set(retention_select, 1'b0)) begin
        next_state = SEEK;
        next_seg = '0;
        next_elapsed = '0;
        next_had_active = 1'b0;
      end
    end else if (run_req && (state == IDLE || state == HOLD)) begin
      next_state = SEEK;
      next_had_active = 1'b0;
      if (digit_set(retention_select, 1'b1) && saved_valid) begin
        next_seg = saved_stage;
        next_elapsed = saved_elapsed;
      end else begin
        next_seg = '0;
        next_elapsed = '0;
      end
      next_saved_valid = 1'b0;
    end else begin
      unique case (state)
        IDLE, HOLD: begin
        end
        SEEK: begin
          next_state = FETCH;
        end
        FETCH: begin
          if (mem_q_seq.run_time == '0) begin
            step = 1'b1;
          end else begin
            next_cur = mem_q_seq;
            next_had_active = 1'b1;
            next_state = RUN;
          end
        end
        RUN: begin
          if (elapsed >= cur.run_time) begin
            step = 1'b1;
          end else if (unit_tick) begin
            next_elapsed = elapsed + TIME_W'(1);
          end
        end
      endcase
    end
    if (step) begin
      next_elapsed = '0;
      if (seg == SEG_IDX_W'(SEG_COUNT - 1)) begin
        next_cycle_done = 1'b1;
        next_seg = '0;
        if (!next_had_active) begin
          next_state = IDLE;
        end else if (eoc_mode == EOC_HOLD) begin
          next_state = HOLD;
        end else if (eoc_mode == EOC_REPEAT) begin
          next_state = SEEK;
          next_had_active = 1'b0;
        end else begin
          next_state = IDLE;
        end
      end else begin
        next_seg = seg + SEG_IDX_W'(1);
        next_state = SEEK;
      end
    end
    drive_on = (next_state != IDLE) && !next_power_lost && next_had_active;
    next_running = next_state != IDLE;
    next_cmd = '0;
    if (drive_on) begin
      next_cmd.ramp = next_cur.ramp;
      if (target == TARGET_FREQ) begin
        next_cmd.freq = magnitude(next_cur.setpoint);
        next_cmd.reverse = next_cur.setpoint < 0;
      end else begin
        next_cmd.volt = magnitude(next_cur.setpoint);
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
      state <= IDLE;
      seg <= '0;
      elapsed <= '0;
      cur <= '0;
      had_active <= 1'b0;
      power_lost <= 1'b0;
      saved_valid <= 1'b0;
      saved_stage <= '0;
      saved_elapsed <= '0;
      saved_sp <= '0;
      cmd <= '0;
      RUNNING <= 1'b0;
      STAGE <= '0;
      CYCLE_DONE <= 1'b0;
    end else begin
      pf_meta <= POWER_FAIL;
      pf_sync <= pf_meta;
      state <= next_state;
      seg <= next_seg;
      elapsed <= next_elapsed;
      cur <= next_cur;
      had_active <= next_had_active;
      power_lost <= next_power_lost;
      saved_valid <= next_saved_valid;
      saved_stage <= next_saved_stage;
      saved_elapsed <= next_saved_elapsed;
      saved_sp <= next_saved_sp;
      cmd <= next_cmd;
      RUNNING <= next_running;
      STAGE <= next_seg;
      CYCLE_DONE <= next_cycle_done;
    end
  end

  assign FREQ_COMMAND = cmd.freq;
  assign REVERSE = cmd.reverse;
  assign VOLTAGE_COMMAND = cmd.volt;
  assign RAMP_SET = cmd.ramp;
endmodule
`default_nettype wire

// [verilog/seg_mem.sv]
// Segment table memory with field-masked writes and two registered read ports.
`timescale 1ns/1ps
`default_nettype none
module seg_mem (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic we,
  input wire logic write_time,
  input wire logic [seq_pkg::SEG_IDX_W-1:0] waddr,
  input wire seq_pkg::seg_s wdata,
  input wire logic [seq_pkg::SEG_IDX_W-1:0] raddr_a,
  output seq_pkg::seg_s rdata_a,
  input wire logic [seq_pkg::SEG_IDX_W-1:0] raddr_b,
  output seq_pkg::seg_s rdata_b
);
  import seq_pkg::*;

  seg_s mem [SEG_COUNT];
  seg_s next_mem [SEG_COUNT];

  always_comb begin
    next_mem = mem;
    if (we) begin
      if (write_time) begin
        next_mem[waddr].run_time = wdata.run_time;
        next_mem[waddr].ramp = wdata.ramp;
      end else begin
        next_mem[waddr].setpoint = wdata.setpoint;
      end
    end
  end

  // Every segment resets to zero time, ramp set 0 and zero setpoint.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < SEG_COUNT; i++) begin
        mem[i] <= '0;
      end
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      mem <= next_mem;
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule
`default_nettype wire

// [verilog/tick_divider.sv]
// Enable-gated divider that emits a one-cycle pulse every period enabled cycles.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int WIDTH = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic clear,
  input wire logic [WIDTH-1:0] period,
  output logic tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      if (count >= period - WIDTH'(1)) begin
        next_count = '0;
        next_tick = 1'b1;
      end else begin
        next_count = count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule
`default_nettype wire
